// file: dv/eac_core_model.sv
// core model: issues single i/o accesses to the eeprom controller
// assumes its task is called at a falling edge of mclk
`timescale 1ns/1ns
module eac_core_model
(
    input wire logic mclk,
    input wire logic cpu_halt,
    input wire logic [7:0] acc_rdata,
    input wire logic acc_bit_test,
    output logic [7:0] acc_addr,
    output logic acc_data_space,
    output logic acc_rd,
    output logic acc_wr,
    output logic [7:0] acc_wdata,
    output logic acc_bit_set,
    output logic acc_bit_clr,
    output logic [2:0] acc_bit_idx
);
    logic [7:0] rd_q;
    logic bt_q;
    logic [7:0] halt_n;
    logic hung = 1'b0; // a stall outlasted its bound

    // idle bus from time zero
    initial
    begin
        {acc_addr, acc_data_space, acc_wdata, acc_bit_idx} = '0;
        {acc_rd, acc_wr, acc_bit_set, acc_bit_clr} = '0;
    end

    // kind is {read, write, bit set, bit clear}; only mapped registers
    // are addressed and top control bits go out as zero
    task automatic access(input logic [7:0] a, input logic ds,
        input logic [3:0] kind, input logic [7:0] d,
        input logic [2:0] b);
        int n;
        n = 0;
        // a stalled core issues nothing
        while (cpu_halt !== 1'b0 && n < 16)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 16)
            hung = 1'b1;
        {acc_addr, acc_data_space, acc_wdata, acc_bit_idx} = {a, ds, d, b};
        {acc_rd, acc_wr, acc_bit_set, acc_bit_clr} = kind;
        @(negedge mclk);
        {acc_rd, acc_wr, acc_bit_set, acc_bit_clr} = 4'h0;
        rd_q = acc_rdata;
        bt_q = acc_bit_test;
        halt_n = 8'h00;
        while (cpu_halt === 1'b1 && halt_n < 8'h10)
        begin
            @(negedge mclk);
            halt_n++;
        end
        if (halt_n >= 8'h10)
            hung = 1'b1;
        // idle edge so the next strobe is a fresh one
        @(negedge mclk);
    endtask
endmodule // eac_core_model

// file: dv/test_eac_eeprom_ctrl.sv
// bench for the eeprom access controller, driven through the core model
// assumes shortened programming counts and a 25 MHz oscillator level
`timescale 1ns/1ns
module test_eac_eeprom_ctrl
    import eac_pkg::*;
;
    localparam int AT = 20;
    localparam int SP = 10;
    localparam logic [7:0] A_CTRL = {2'b00, EAC_OFF_CTRL};
    localparam logic [7:0] A_DATA = {2'b00, EAC_OFF_DATA};
    localparam logic [7:0] A_LO = {2'b00, EAC_OFF_ADDR_LO};
    localparam logic [7:0] A_HI = {2'b00, EAC_OFF_ADDR_HI};
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic por_rst = 1'b1;
    logic global_irq_en = 1'b0;
    logic osc = 1'b0;
    logic [7:0] acc_addr, acc_wdata, acc_rdata;
    logic [2:0] acc_bit_idx;
    logic acc_data_space, acc_rd, acc_wr, acc_bit_set, acc_bit_clr;
    logic acc_bit_test, cpu_halt, ready_irq;
    int errors = 0;
    int num_checks = 0;
    longint t0;

    // core clock 4 ns; oscillator free-running, 40 ns per tick
    always #2 mclk = ~mclk;
    always #20 osc = ~osc;

    eac_eeprom_ctrl #(.ATOMIC_TICKS(AT), .SPLIT_TICKS(SP)) uut
    (
        .mclk(mclk), .rst(rst), .por_rst(por_rst), .acc_addr(acc_addr),
        .acc_data_space(acc_data_space), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata),
        .acc_bit_set(acc_bit_set), .acc_bit_clr(acc_bit_clr),
        .acc_bit_idx(acc_bit_idx), .global_irq_en(global_irq_en),
        .osc_clk_in(osc), .acc_rdata(acc_rdata),
        .acc_bit_test(acc_bit_test), .cpu_halt(cpu_halt),
        .ready_irq(ready_irq)
    );

    eac_core_model core
    (
        .mclk(mclk), .cpu_halt(cpu_halt), .acc_rdata(acc_rdata),
        .acc_bit_test(acc_bit_test), .acc_addr(acc_addr),
        .acc_data_space(acc_data_space), .acc_rd(acc_rd),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata),
        .acc_bit_set(acc_bit_set), .acc_bit_clr(acc_bit_clr),
        .acc_bit_idx(acc_bit_idx)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // a core stall that never ends counts as a mismatch and ends the run
    always @(posedge core.hung)
    begin
        errors++;
        report_and_stop();
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        core.access(a, 1'b0, 4'b0100, d, 3'h0);
    endtask

    task automatic rd(input logic [7:0] a);
        core.access(a, 1'b0, 4'b1000, 8'h00, 3'h0);
    endtask

    task automatic bit_op(input logic [7:0] a, input logic [2:0] b,
        input logic set);
        core.access(a, 1'b0, {2'b00, set, ~set}, 8'h00, b);
    endtask

    task automatic strobe_read(input logic [7:0] exp);
        bit_op(A_CTRL, 3'h0, 1'b1);
        check(core.halt_n, 8'h04);
        rd(A_DATA);
        check(core.rd_q, exp);
    endtask

    // arm the master window, then set program enable two edges later
    task automatic start(input logic [7:0] a, input logic [1:0] m,
        input logic [7:0] d);
        wr(A_LO, a);
        wr(A_DATA, d);
        wr(A_CTRL, {2'b00, m, 4'h8});
        bit_op(A_CTRL, 3'h2, 1'b1);
        bit_op(A_CTRL, 3'h1, 1'b1);
        t0 = $time;
        check(core.halt_n, 8'h02);
    endtask

    // probe the busy refusals, then poll program enable until clear
    task automatic finish(input logic [7:0] a, input logic [1:0] m,
        input int ticks, input logic probe);
        int n;
        longint dt;
        n = 0;
        if (probe)
        begin
            check(ready_irq, 8'h00);
            bit_op(A_CTRL, 3'h0, 1'b1);
            check(core.halt_n, 8'h00);
            wr(A_LO, ~a);
            bit_op(A_CTRL, 3'h5, ~m[1]);
            rd(A_CTRL);
            check(core.rd_q, {2'b00, m, 4'ha});
        end
        rd(A_CTRL);
        while (core.rd_q[1] === 1'b1 && n < 500)
        begin
            rd(A_CTRL);
            n++;
        end
        dt = $time - t0;
        check(8'(n < 500), 8'h01);
        if (n >= 500)
            report_and_stop();
        if (ticks == 0)
            check(8'(n), 8'h00);
        else
            check(8'(dt >= ticks * 40 - 60 && dt <= ticks * 40 + 40),
                8'h01);
        rd(A_LO);
        check(core.rd_q, a);
        if (probe)
            check(ready_irq, 8'h01);
    endtask

    task automatic t_reset();
        rd(A_DATA);
        check(core.rd_q, 8'h00);
        rd(A_CTRL);
        check(core.rd_q, 8'h00);
        wr(A_HI, 8'hff);
        rd(A_HI);
        check(core.rd_q, 8'h00);
    endtask

    task automatic t_alias();
        core.access(A_DATA + EAC_DATA_SPACE_OFS, 1'b1, 4'b0100, 8'h96,
            3'h0);
        rd(A_DATA);
        check(core.rd_q, 8'h96);
        wr(A_LO, 8'h42);
        core.access(A_LO + EAC_DATA_SPACE_OFS, 1'b1, 4'b1000, 8'h00, 3'h0);
        check(core.rd_q, 8'h42);
    endtask

    task automatic t_bits();
        wr(A_DATA, 8'h5a);
        bit_op(A_DATA, 3'h0, 1'b1);
        bit_op(A_DATA, 3'h1, 1'b0);
        // bit set through the data-space alias must be ignored
        core.access(A_DATA + EAC_DATA_SPACE_OFS, 1'b1, 4'b0010, 8'h00,
            3'h2);
        core.access(A_DATA, 1'b0, 4'b1000, 8'h00, 3'h3);
        check(core.rd_q, 8'h59);
        check(core.bt_q, 8'h01);
        core.access(A_DATA, 1'b0, 4'b1000, 8'h00, 3'h1);
        check(core.bt_q, 8'h00);
        bit_op(A_CTRL, 3'h3, 1'b1);
        rd(A_CTRL);
        check(core.rd_q, 8'h08);
    endtask

    task automatic t_irq();
        repeat (2) @(negedge mclk);
        check(ready_irq, 8'h00);
        global_irq_en = 1'b1;
        repeat (2) @(negedge mclk);
        check(ready_irq, 8'h01);
    endtask

    task automatic t_master();
        bit_op(A_CTRL, 3'h1, 1'b1);
        check(core.halt_n, 8'h00);
        bit_op(A_CTRL, 3'h2, 1'b1);
        rd(A_CTRL);
        check(core.rd_q, 8'h0c);
        bit_op(A_CTRL, 3'h2, 1'b1);
        repeat (3) @(negedge mclk);
        bit_op(A_CTRL, 3'h1, 1'b1);
        check(core.halt_n, 8'h00);
        rd(A_CTRL);
        check(core.rd_q, 8'h08);
    endtask

    // every mode once; last entry shows linear addressing
    task automatic t_prog();
        logic [7:0] ad [5] = '{8'h05, 8'h05, 8'h05, 8'h05, 8'hff};
        logic [1:0] md [5] = '{2'b00, 2'b01, 2'b10, 2'b11, 2'b00};
        logic [7:0] dv [5] = '{8'ha5, 8'h00, 8'h3c, 8'h00, 8'h11};
        logic [7:0] ex [5] = '{8'ha5, 8'hff, 8'h3c, 8'h3c, 8'h11};
        int tk [5] = '{AT, SP, SP, 0, AT};
        for (int i = 0; i < 5; i++)
        begin
            start(ad[i], md[i], dv[i]);
            finish(ad[i], md[i], tk[i], tk[i] > 0);
            strobe_read(ex[i]);
        end
        wr(A_LO, 8'h05);
        strobe_read(8'h3c);
    endtask

    // reset in mid-erase keeps mode and busy; idle reset clears them
    task automatic t_reset_busy();
        start(8'h05, 2'b01, 8'h00);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        rd(A_CTRL);
        check(core.rd_q, 8'h12);
        finish(8'h05, 2'b01, SP, 1'b0);
        strobe_read(8'hff);
        rst = 1'b1;
        @(negedge mclk);
        rst = 1'b0;
        rd(A_CTRL);
        check(core.rd_q, 8'h00);
        rd(A_DATA);
        check(core.rd_q, 8'h00);
    endtask

    // reset for four cycles, then the scenarios in order
    initial
    begin
        repeat (4) @(negedge mclk);
        rst = 1'b0;
        por_rst = 1'b0;
        t_reset();
        t_alias();
        t_bits();
        t_irq();
        t_master();
        t_prog();
        t_reset_busy();
        report_and_stop();
    end
endmodule // test_eac_eeprom_ctrl

// file: hw/eac_downcnt.sv
// loadable down counter with a registered active flag
// assumes load requests come from logic on mclk
`timescale 1ns/1ns
module eac_downcnt
#(
    parameter int WIDTH = 3
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] load_val,
    output logic active
);
    logic [WIDTH-1:0] cnt;
    logic [WIDTH-1:0] next_cnt;

    // a zero-width counter cannot hold any window
    if (WIDTH < 1)
    begin : g_bad_width
        $error("eac_downcnt: WIDTH must be at least 1");
    end

    // count down to zero, a load always wins
    always_comb
    begin
        if (load)
            next_cnt = load_val;
        else if (cnt != '0)
            next_cnt = cnt - WIDTH'(1);
        else
            next_cnt = cnt;
    end

    // active is a flop so it can drive a port directly
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cnt <= '0;
            active <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            active <= (next_cnt != '0);
        end
    end
endmodule // eac_downcnt

// file: hw/eac_eeprom_ctrl.sv
// data eeprom access controller: registers, sequencing and array
// assumes a core issuing one i/o access per cycle on mclk and a
// calibrated oscillator delivered as a free-running level
`timescale 1ns/1ns
module eac_eeprom_ctrl
    import eac_pkg::*;
#(
    parameter int ATOMIC_TICKS = EAC_ATOMIC_TICKS,
    parameter int SPLIT_TICKS = EAC_SPLIT_TICKS,
    parameter int TICK_W = 16
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic por_rst,
    input wire logic [7:0] acc_addr,
    input wire logic acc_data_space,
    input wire logic acc_rd,
    input wire logic acc_wr,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_bit_set,
    input wire logic acc_bit_clr,
    input wire logic [2:0] acc_bit_idx,
    input wire logic global_irq_en,
    input wire logic osc_clk_in,
    output logic [7:0] acc_rdata,
    output logic acc_bit_test,
    output logic cpu_halt,
    output logic ready_irq
);
    // elaboration guard on the programming counter width
    if (ATOMIC_TICKS < 1 || SPLIT_TICKS < 1 ||
        ATOMIC_TICKS >= (1 << TICK_W) || SPLIT_TICKS >= (1 << TICK_W))
    begin : g_bad_ticks
        $error("eac_eeprom_ctrl: tick counts do not fit TICK_W");
    end

    logic [7:0] mem [256];
    logic [7:0] nvm_data_reg;
    logic [7:0] nvm_addr_low_reg;
    logic [1:0] prog_mode_field;
    logic ready_irq_enable;
    logic master_prog_enable;
    logic prog_enable;
    logic [TICK_W-1:0] prog_cnt;
    eac_mode_t op_mode;
    logic [7:0] op_addr;
    logic [7:0] op_data;
    logic osc_sync;
    logic osc_prev;
    logic osc_tick;
    logic [5:0] reg_idx;
    logic reg_ok;
    logic bit_ok;
    logic bit_op;
    logic wr_any;
    logic [7:0] wmask;
    logic [7:0] wval;
    logic hit_ctrl;
    logic hit_data;
    logic hit_addr;
    logic master_load;
    logic [2:0] master_val;
    logic start_req;
    logic start_ok;
    logic read_req;
    logic read_ok;
    logic halt_load;
    logic [2:0] halt_val;
    logic [7:0] ctrl_view;
    logic [7:0] rd_byte;
    logic [7:0] sel_byte;
    logic prog_done;

    // oscillator edge: two flops, then an edge compare on the output
    eac_sync2 u_osc_sync
    (
        .mclk(mclk),
        .rst(por_rst),
        .din(osc_clk_in),
        .dout(osc_sync)
    );

    always_ff @(posedge mclk)
    begin
        if (por_rst)
            osc_prev <= 1'b0;
        else
            osc_prev <= osc_sync;
    end

    assign osc_tick = osc_sync & ~osc_prev;

    // address decode: direct i/o or the data-space alias
    always_comb
    begin
        if (acc_data_space)
        begin
            reg_idx = 6'(acc_addr - EAC_DATA_SPACE_OFS);
            reg_ok = (acc_addr >= EAC_DATA_SPACE_OFS) &&
                (acc_addr < EAC_DATA_SPACE_END);
        end
        else
        begin
            reg_idx = acc_addr[5:0];
            reg_ok = (acc_addr < EAC_IO_SPACE_END);
        end
    end

    // bit access exists only on the low i/o page, not via the alias
    assign bit_ok = ~acc_data_space && (acc_addr <= EAC_BIT_ACCESS_MAX);
    assign bit_op = (acc_bit_set | acc_bit_clr) & bit_ok;

    // a bit op carries a one-hot mask so other bits are not written
    always_comb
    begin
        if (bit_op)
        begin
            wmask = 8'h01 << acc_bit_idx;
            wval = acc_bit_set ? wmask : 8'h00;
        end
        else
        begin
            wmask = 8'hff;
            wval = acc_wdata;
        end
    end

    assign wr_any = (acc_wr & reg_ok) | bit_op;
    assign hit_ctrl = wr_any && (reg_idx == EAC_OFF_CTRL);
    assign hit_data = wr_any && (reg_idx == EAC_OFF_DATA);
    assign hit_addr = wr_any && (reg_idx == EAC_OFF_ADDR_LO);

    // control strobes decoded from the masked write
    assign master_load = hit_ctrl & wmask[EAC_BIT_MASTER];
    assign master_val = wval[EAC_BIT_MASTER] ? EAC_MASTER_CYCLES : 3'd0;
    assign start_req = hit_ctrl & wmask[EAC_BIT_PROG] & wval[EAC_BIT_PROG];
    // no master window or already busy: the program bit has no effect
    assign start_ok = start_req & master_prog_enable & ~prog_enable;
    assign read_req = hit_ctrl & wmask[EAC_BIT_RDSTB] & wval[EAC_BIT_RDSTB];
    assign read_ok = read_req & ~prog_enable;

    // master enable window, four core cycles from the write
    eac_downcnt #(.WIDTH(3)) u_master
    (
        .mclk(mclk),
        .rst(rst),
        .load(master_load),
        .load_val(master_val),
        .active(master_prog_enable)
    );

    // core stall: two cycles for a start, four for a read, also when a read comes with a start
    assign halt_load = start_ok | read_ok;
    assign halt_val = read_ok ? EAC_READ_STALL : EAC_PROG_STALL;

    eac_downcnt #(.WIDTH(3)) u_halt
    (
        .mclk(mclk),
        .rst(rst),
        .load(halt_load),
        .load_val(halt_val),
        .active(cpu_halt)
    );

    // mode field: frozen while busy, kept through reset when busy
    always_ff @(posedge mclk)
    begin
        if (por_rst)
            prog_mode_field <= EAC_RST_MODE;
        else if (rst)
        begin
            if (!prog_enable)
                prog_mode_field <= EAC_RST_MODE;
        end
        else if (hit_ctrl && !prog_enable)
        begin
            prog_mode_field <= (prog_mode_field & ~wmask[5:4]) |
                (wval[5:4] & wmask[5:4]);
        end
    end

    // ready interrupt enable
    always_ff @(posedge mclk)
    begin
        if (rst || por_rst)
            ready_irq_enable <= 1'b0;
        else if (hit_ctrl && wmask[EAC_BIT_RDY_IEN])
            ready_irq_enable <= wval[EAC_BIT_RDY_IEN];
    end

    // programming sequencer; only power-on stops it, not rst
    assign prog_done = prog_enable && osc_tick &&
        (prog_cnt == TICK_W'(1));

    always_ff @(posedge mclk)
    begin
        if (por_rst)
        begin
            prog_enable <= 1'b0;
            prog_cnt <= '0;
            op_mode <= EAC_MODE_ATOMIC;
            op_addr <= 8'h00;
            op_data <= 8'h00;
        end
        else if (start_ok && !rst)
        begin
            op_mode <= eac_mode_t'(prog_mode_field);
            op_addr <= nvm_addr_low_reg;
            op_data <= nvm_data_reg;
            unique case (eac_mode_t'(prog_mode_field))
                EAC_MODE_ATOMIC:
                begin
                    prog_enable <= 1'b1;
                    prog_cnt <= TICK_W'(ATOMIC_TICKS);
                end
                EAC_MODE_ERASE, EAC_MODE_WRITE:
                begin
                    prog_enable <= 1'b1;
                    prog_cnt <= TICK_W'(SPLIT_TICKS);
                end
                EAC_MODE_RSVD:
                begin
                    prog_enable <= 1'b0;
                    prog_cnt <= '0;
                end
            endcase
        end
        else if (prog_enable && osc_tick)
        begin
            prog_cnt <= prog_cnt - TICK_W'(1);
            if (prog_cnt == TICK_W'(1))
                prog_enable <= 1'b0;
        end
    end

    // array update at the end; write-only just clears bits
    always_ff @(posedge mclk)
    begin
        if (prog_done)
        begin
            unique case (op_mode)
                EAC_MODE_ATOMIC: mem[op_addr] <= op_data;
                EAC_MODE_ERASE: mem[op_addr] <= EAC_ERASED_BYTE;
                EAC_MODE_WRITE: mem[op_addr] <= mem[op_addr] & op_data;
                EAC_MODE_RSVD: mem[op_addr] <= mem[op_addr];
            endcase
        end
    end

    // low address: no reset value, locked while programming
    always_ff @(posedge mclk)
    begin
        if (hit_addr && !prog_enable)
        begin
            nvm_addr_low_reg <= (nvm_addr_low_reg & ~wmask) |
                (wval & wmask);
        end
    end

    assign rd_byte = mem[nvm_addr_low_reg];

    // data register: software writes, or the byte of a read strobe
    always_ff @(posedge mclk)
    begin
        if (rst || por_rst)
            nvm_data_reg <= EAC_RST_DATA;
        else if (read_ok)
            nvm_data_reg <= rd_byte;
        else if (hit_data)
            nvm_data_reg <= (nvm_data_reg & ~wmask) | (wval & wmask);
    end

    // control readback; read strobe bit self-clears so reads zero
    assign ctrl_view = {2'b00, prog_mode_field, ready_irq_enable,
        master_prog_enable, prog_enable, 1'b0};

    // read mux; high address and unmapped offsets read zero
    always_comb
    begin
        sel_byte = 8'h00;
        if (reg_ok)
        begin
            if (reg_idx == EAC_OFF_CTRL)
                sel_byte = ctrl_view;
            else if (reg_idx == EAC_OFF_DATA)
                sel_byte = nvm_data_reg;
            else if (reg_idx == EAC_OFF_ADDR_LO)
                sel_byte = nvm_addr_low_reg;
        end
    end

    // read data and bit test both come one cycle after the request
    always_ff @(posedge mclk)
    begin
        if (rst || por_rst)
        begin
            acc_rdata <= 8'h00;
            acc_bit_test <= 1'b0;
        end
        else if (acc_rd)
        begin
            acc_rdata <= sel_byte;
            acc_bit_test <= bit_ok & sel_byte[acc_bit_idx];
        end
    end

    // level interrupt while idle; global enable comes from the core
    always_ff @(posedge mclk)
    begin
        if (rst || por_rst)
            ready_irq <= 1'b0;
        else
            ready_irq <= ready_irq_enable & global_irq_en &
                ~prog_enable;
    end

    // checks
    a_hi_addr_zero: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (acc_rd && reg_ok && reg_idx == EAC_OFF_ADDR_HI)
        |=> acc_rdata == 8'h00)
        else $error("high address register read nonzero");

    a_ctrl_top_zero: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (acc_rd && reg_ok && reg_idx == EAC_OFF_CTRL)
        |=> acc_rdata[7:6] == 2'b00)
        else $error("control top bits read nonzero");

    a_mode_frozen: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (prog_enable && hit_ctrl)
        |=> $stable(prog_mode_field))
        else $error("mode changed while programming");

    a_start_gated: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (start_req && !master_prog_enable && !prog_enable)
        |=> !prog_enable && !cpu_halt)
        else $error("program started without master enable");

    a_master_four: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (master_load && wval[EAC_BIT_MASTER])
        ##1 (!master_load)[*4]
        |=> master_prog_enable == 1'b0)
        else $error("master enable window not four cycles");

    a_prog_stall: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (start_ok && prog_mode_field != EAC_MODE_RSVD)
        |=> (cpu_halt && prog_enable)[*2] ##1 !cpu_halt)
        else $error("program start stall is not two cycles");

    a_read_stall: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        read_ok |=> cpu_halt[*4] ##1 !cpu_halt)
        else $error("read stall is not four cycles");

    a_read_data: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        read_ok |=> nvm_data_reg == $past(rd_byte))
        else $error("read strobe did not load the array byte");

    a_busy_locks: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        prog_enable |=> $stable(nvm_addr_low_reg) &&
            (!$past(read_req) || $stable(nvm_data_reg)))
        else $error("address or read accepted while busy");

    a_bit_only: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (bit_op && hit_data && !read_ok)
        |=> ((nvm_data_reg ^ $past(nvm_data_reg)) & ~$past(wmask))
            == 8'h00)
        else $error("bit operation touched other bits");

    a_rsvd_noop: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (start_ok && prog_mode_field == EAC_MODE_RSVD)
        |=> !prog_enable)
        else $error("reserved mode started programming");

    a_irq_idle: assert property (
        @(posedge mclk) disable iff (rst || por_rst)
        (prog_enable ##1 prog_enable) |-> !ready_irq)
        else $error("ready interrupt while programming");

    a_reset_keeps: assert property (
        @(posedge mclk) disable iff (por_rst)
        (rst && prog_enable && !prog_done)
        |=> prog_enable && $stable(prog_mode_field))
        else $error("reset aborted programming");
endmodule // eac_eeprom_ctrl

// file: hw/eac_sync2.sv
// two-flop synchroniser for one level from another domain
// assumes the input may change at any time relative to mclk
`timescale 1ns/1ns
module eac_sync2
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic meta;

    // first flop only feeds the second one
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            dout <= 1'b0;
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // eac_sync2

// file: include/eac_pkg.sv
// constants for the data eeprom access controller
// assumes the core clock mclk and an 8-bit i/o register space
package eac_pkg;
    // i/o register offsets, data-space alias adds a fixed offset
    localparam logic [5:0] EAC_OFF_CTRL = 6'h1c;
    localparam logic [5:0] EAC_OFF_DATA = 6'h1d;
    localparam logic [5:0] EAC_OFF_ADDR_LO = 6'h1e;
    localparam logic [5:0] EAC_OFF_ADDR_HI = 6'h1f;
    localparam logic [7:0] EAC_DATA_SPACE_OFS = 8'h20;
    localparam logic [7:0] EAC_DATA_SPACE_END = 8'h60;
    localparam logic [7:0] EAC_IO_SPACE_END = 8'h40;
    localparam logic [7:0] EAC_BIT_ACCESS_MAX = 8'h1f;
    // control register field positions
    localparam int EAC_BIT_MODE_HI = 5;
    localparam int EAC_BIT_MODE_LO = 4;
    localparam int EAC_BIT_RDY_IEN = 3;
    localparam int EAC_BIT_MASTER = 2;
    localparam int EAC_BIT_PROG = 1;
    localparam int EAC_BIT_RDSTB = 0;
    // reset values and the erased array byte
    localparam logic [7:0] EAC_RST_DATA = 8'h00;
    localparam logic [1:0] EAC_RST_MODE = 2'b00;
    localparam logic [7:0] EAC_ERASED_BYTE = 8'hff;
    // programming modes
    typedef enum logic [1:0] {
        EAC_MODE_ATOMIC = 2'b00,
        EAC_MODE_ERASE = 2'b01,
        EAC_MODE_WRITE = 2'b10,
        EAC_MODE_RSVD = 2'b11
    } eac_mode_t;
    // timing: programming times run on the calibrated oscillator
    localparam longint EAC_T_ATOMIC_NS = 3400000;
    localparam longint EAC_T_SPLIT_NS = 1800000;
    localparam longint EAC_OSC_KHZ = 8000;
    localparam int EAC_ATOMIC_TICKS =
        int'((EAC_T_ATOMIC_NS * EAC_OSC_KHZ) / 64'd1000000);
    localparam int EAC_SPLIT_TICKS =
        int'((EAC_T_SPLIT_NS * EAC_OSC_KHZ) / 64'd1000000);
    // core-clock windows and stalls
    localparam logic [2:0] EAC_MASTER_CYCLES = 3'd4;
    localparam logic [2:0] EAC_PROG_STALL = 3'd2;
    localparam logic [2:0] EAC_READ_STALL = 3'd4;
endpackage
